// file: brc_pkg.sv
// Package: register map, reset values, timing constants and state types of the BCD calendar clock
package brc_pkg;
   // Register indices
   localparam logic [2:0] ADDR_SEC  = 3'h0;
   localparam logic [2:0] ADDR_MIN  = 3'h1;
   localparam logic [2:0] ADDR_HOUR = 3'h2;
   localparam logic [2:0] ADDR_WDAY = 3'h3;
   localparam logic [2:0] ADDR_DATE = 3'h4;
   localparam logic [2:0] ADDR_MON  = 3'h5;
   localparam logic [2:0] ADDR_YEAR = 3'h6;
   localparam logic [2:0] ADDR_CTRL = 3'h7;
   // Field positions
   localparam int BIT_OSC_STOP = 7;
   localparam int BIT_OSC_FAIL = 7;
   localparam int BIT_CENT_EN  = 7;
   localparam int BIT_CENT     = 6;
   localparam int BIT_OUT_LVL  = 7;
   localparam int BIT_FREQ_EN  = 6;
   localparam int BIT_PWR_FAIL = 0;
   // Values after reset, index 7 first
   localparam logic [7:0][7:0] RST_REGS = {8'h81, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h80, 8'h00};
   // Bits software may write, index 7 first; clear bits keep their value on a write, save the fail and power fail flags
   localparam logic [7:0][7:0] WR_MASK  = {8'hC0, 8'hFF, 8'h1F, 8'h3F, 8'h07, 8'hFF, 8'h7F, 8'hFF};
   // BCD counter limits
   localparam logic [6:0] SEC_LAST  = 7'h59;
   localparam logic [5:0] HOUR_LAST = 6'h23;
   localparam logic [2:0] WDAY_LAST = 3'h7;
   localparam logic [4:0] MON_LAST  = 5'h12;
   localparam logic [7:0] YEAR_LAST = 8'h99;
   // Serial slave identifier; value is arbitrary
   localparam logic [6:0] DEV_ID = 7'h2A;
   // Bit counter positions of the acknowledge slot
   localparam logic [3:0] BIT_ACK     = 4'h8;
   localparam logic [3:0] BIT_ACK_END = 4'h9;
   // Timebase and oscillator watchdog
   localparam int          CLK_PERIOD_NS   = 20;
   localparam int          XTAL_HZ         = 32768;
   localparam int          OSC_TIMEOUT_NS  = 100000;
   localparam int          OSC_TIMEOUT_CYC = OSC_TIMEOUT_NS / CLK_PERIOD_NS;
   localparam logic [14:0] DIV_LAST        = 15'h7FFF;
   localparam int          DIV_TAP_512     = 5;
   // Serial transfer phase
   typedef enum logic [2:0] {sIdle, sAddr, sReg, sWrite, sRead} brc_bus_t;
   // Pins that are synchronised together
   typedef struct packed {
      logic scl;
      logic sda;
      logic xtl;
   } brc_pins_t;
   // Level of the synchronised pins while the bus and timebase idle
   localparam brc_pins_t PINS_IDLE = '{scl: 1'b1, sda: 1'b1, xtl: 1'b0};
   // Whole state of the clock
   typedef struct packed {
      logic [7:0][7:0] regs;
      logic [7:0][7:0] shadow;
      logic [2:0]      ptr;
      brc_bus_t        bus;
      logic [3:0]      bitCnt;
      logic [7:0]      shifter;
      logic [7:0]      txByte;
      logic            rwBit;
      logic            masterNack;
      brc_pins_t       s1;
      brc_pins_t       s2;
      brc_pins_t       d;
      logic [15:0]     oscCnt;
      logic [14:0]     div;
      logic            sdaOe;
      logic            dualOe;
      logic            odLevel;
   } brc_state_t;
endpackage : brc_pkg

// file: brc_rtc.sv
// BCD calendar clock with serial register slave and open-drain output pin
//
// Overview of operation
// - Timebase is 32.768 kHz crystal pin input
// - Control register bits choose output pin function
// - Output pin is open drain, released after reset
// - Count only while oscillator runs validly
// - Time registers hold tens and units BCD
// - Seconds, minutes count 0 to 59, carry on wrap
// - Hours count 0 to 23, wrap advances day
// - Weekday counts one to seven, back to one
// - Date to month length, month 1-12, year 0-99
// - Every year divisible by four is leap
// - Oscillator stop bit freezes counting, resets zero
// - Fail flag set without oscillation, write clears
// - Century bit toggles at year wrap if enabled
// - Address increments per byte, wraps 7 to 0
// - Read start copies registers into holding buffer
// - Pointer ends one past last register accessed
// - Master may read any register, then sequentially
// - Reset loads documented register defaults
// - Device is slave, all bits on master clock
// - Frequency enable drives 512 Hz, resets zero
// - Output level bit sets static pin, resets one
// - Power fail flag cleared by first time write
// - Read continues while master acknowledges each byte
`timescale 1ns/1ps
`default_nettype none
module brc_rtc #(
   parameter int OSC_TIMEOUT = brc_pkg::OSC_TIMEOUT_CYC  // Idle cycles before oscillator fails
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_b,
   // Timebase pin
   input  wire logic crystalIn,
   // Serial bus pins
   input  wire logic sclIn,
   input  wire logic sdaIn,
   output logic      sdaOut,
   output logic      sdaOe,
   // Dual-purpose output pin
   output logic      dualOut,
   output logic      dualOe
);
   import brc_pkg::*;

   brc_state_t st_r;    // Registered state
   brc_state_t st_nxt;  // Next state
   logic       wrEn;    // Register write this cycle
   logic       tick;    // One-second tick this cycle
   logic       oscRun;  // Oscillator running and not stopped
   logic       sclRise; // Serial clock rising
   logic       sclFall; // Serial clock falling
   logic       startC;  // Start condition seen
   logic       stopC;   // Stop condition seen
   logic       xtlRise; // Crystal rising edge
   logic [7:0] wData;   // Byte written by master
   logic       sec59;   // Seconds at last value
   logic       min59;   // Minutes at last value
   logic       hr23;    // Hours at last value
   logic       dayLast; // Date at month end

   // Increment of a two-digit BCD value
   function automatic logic [7:0] bcdInc(input logic [7:0] v);
      bcdInc = (v[3:0] == 4'h9) ? {4'(v[7:4] + 4'h1), 4'h0} : {v[7:4], 4'(v[3:0] + 4'h1)};
   endfunction : bcdInc

   // Days in the month; no century exception, so year 00 is always leap
   function automatic logic [5:0] monthLen(input logic [4:0] mon, input logic [7:0] yr);
      logic leap;
      leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                   : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
      if (mon == 5'h02) begin
         monthLen = leap ? 6'h29 : 6'h28;
      end else if (mon == 5'h04 || mon == 5'h06 || mon == 5'h09 || mon == 5'h11) begin
         monthLen = 6'h30;
      end else begin
         monthLen = 6'h31;
      end
   endfunction : monthLen

   // Edge and condition detection on synchronised pins only
   assign sclRise = st_r.s2.scl && !st_r.d.scl;
   assign sclFall = !st_r.s2.scl && st_r.d.scl;
   assign startC  = st_r.s2.scl && st_r.d.scl && st_r.d.sda && !st_r.s2.sda;
   assign stopC   = st_r.s2.scl && st_r.d.scl && !st_r.d.sda && st_r.s2.sda;
   assign xtlRise = st_r.s2.xtl && !st_r.d.xtl;
   assign oscRun  = (st_r.oscCnt < 16'(OSC_TIMEOUT)) &&
                    !st_r.regs[ADDR_SEC][BIT_OSC_STOP];
   assign wData   = st_r.shifter;
   assign sec59   = st_r.regs[ADDR_SEC][6:0] == SEC_LAST;
   assign min59   = st_r.regs[ADDR_MIN][6:0] == SEC_LAST;
   assign hr23    = st_r.regs[ADDR_HOUR][5:0] == HOUR_LAST;
   assign dayLast = st_r.regs[ADDR_DATE][5:0] ==
                    monthLen(st_r.regs[ADDR_MON][4:0], st_r.regs[ADDR_YEAR]);

   // All next-state logic
   always_comb begin
      st_nxt = st_r;
      wrEn   = 1'b0;
      tick   = 1'b0;
      // Three stages: first two synchronise, third gives edges
      st_nxt.s1 = {sclIn, sdaIn, crystalIn};
      st_nxt.s2 = st_r.s1;
      st_nxt.d  = st_r.s2;
      // Watchdog on crystal activity, saturating
      if (st_r.s2.xtl != st_r.d.xtl) begin
         st_nxt.oscCnt = 16'h0000;
      end else if (st_r.oscCnt < 16'(OSC_TIMEOUT)) begin
         st_nxt.oscCnt = st_r.oscCnt + 16'h0001;
      end
      // Divider chain: wrap gives the second, bit five gives 512 Hz
      if (oscRun && xtlRise) begin
         st_nxt.div = st_r.div + 15'h0001;
         tick       = st_r.div == DIV_LAST;
      end
      // Serial slave; start and stop override any bit in flight
      if (startC) begin
         st_nxt.bus    = sAddr;
         st_nxt.bitCnt = 4'h0;
         st_nxt.sdaOe  = 1'b0;
      end else if (stopC) begin
         st_nxt.bus   = sIdle;
         st_nxt.sdaOe = 1'b0;
      end else if (st_r.bus != sIdle) begin
         if (sclRise) begin
            // Sample data bits and the master acknowledge on rising clock
            if (st_r.bitCnt < BIT_ACK) begin
               st_nxt.shifter = {st_r.shifter[6:0], st_r.s2.sda};
            end
            if (st_r.bitCnt == BIT_ACK && st_r.bus == sRead) begin
               st_nxt.masterNack = st_r.s2.sda;
               st_nxt.ptr        = st_r.ptr + 3'h1;
            end
            st_nxt.bitCnt = st_r.bitCnt + 4'h1;
         end else if (sclFall) begin
            if (st_r.bitCnt == BIT_ACK) begin
               // Byte complete: act on it and drive the acknowledge
               unique case (st_r.bus)
                  sAddr: begin
                     if (wData[7:1] == DEV_ID) begin
                        st_nxt.sdaOe = 1'b1;
                        st_nxt.rwBit = wData[0];
                        if (wData[0]) begin
                           st_nxt.shadow = st_r.regs;
                        end
                     end else begin
                        st_nxt.bus = sIdle;                                       // Not ours
                     end
                  end
                  sReg: begin
                     st_nxt.ptr   = wData[2:0];
                     st_nxt.sdaOe = 1'b1;
                  end
                  sWrite: begin
                     wrEn = 1'b1;
                     st_nxt.regs[st_r.ptr] = (wData & WR_MASK[st_r.ptr]) |
                                             (st_r.regs[st_r.ptr] & ~WR_MASK[st_r.ptr]);
                     if (st_r.ptr == ADDR_MIN) begin
                        // Fail flag only clears while the oscillator runs
                        st_nxt.regs[ADDR_MIN][BIT_OSC_FAIL] =
                           st_r.regs[ADDR_MIN][BIT_OSC_FAIL] &
                           (wData[BIT_OSC_FAIL] | !oscRun);
                     end
                     if (st_r.ptr != ADDR_CTRL) begin
                        st_nxt.regs[ADDR_CTRL][BIT_PWR_FAIL] = 1'b0;
                     end
                     st_nxt.ptr   = st_r.ptr + 3'h1;
                     st_nxt.sdaOe = 1'b1;
                  end
                  sRead: begin
                     st_nxt.sdaOe = 1'b0;                                         // Master acks
                  end
                  sIdle: begin
                  end
               endcase
            end else if (st_r.bitCnt == BIT_ACK_END) begin
               // Acknowledge slot over: release or start the next byte
               st_nxt.bitCnt = 4'h0;
               st_nxt.sdaOe  = 1'b0;
               unique case (st_r.bus)
                  sAddr: begin
                     st_nxt.bus = st_r.rwBit ? sRead : sReg;
                     if (st_r.rwBit) begin
                        st_nxt.txByte = st_r.shadow[st_r.ptr];
                        st_nxt.sdaOe  = !st_r.shadow[st_r.ptr][7];
                     end
                  end
                  sReg: begin
                     st_nxt.bus = sWrite;
                  end
                  sWrite: begin
                  end
                  sRead: begin
                     if (st_r.masterNack) begin
                        st_nxt.bus = sIdle;
                     end else begin
                        st_nxt.txByte = st_r.shadow[st_r.ptr];
                        st_nxt.sdaOe  = !st_r.shadow[st_r.ptr][7];
                     end
                  end
                  sIdle: begin
                  end
               endcase
            end else if (st_r.bus == sRead) begin
               // Shift out the next data bit, MSB first
               st_nxt.txByte = {st_r.txByte[6:0], 1'b0};
               st_nxt.sdaOe  = !st_r.txByte[6];
            end
         end
      end
      // Calendar advance; a register write in the same cycle wins
      if (tick && !wrEn) begin
         st_nxt.regs[ADDR_SEC][6:0] = sec59 ? 7'h00 :
                                      7'(bcdInc({1'b0, st_r.regs[ADDR_SEC][6:0]}));
         if (sec59) begin
            st_nxt.regs[ADDR_MIN][6:0] = min59 ? 7'h00 :
                                         7'(bcdInc({1'b0, st_r.regs[ADDR_MIN][6:0]}));
            if (min59) begin
               st_nxt.regs[ADDR_HOUR][5:0] = hr23 ? 6'h00 :
                                             6'(bcdInc({2'b00, st_r.regs[ADDR_HOUR][5:0]}));
               if (hr23) begin
                  st_nxt.regs[ADDR_WDAY][2:0] = (st_r.regs[ADDR_WDAY][2:0] == WDAY_LAST) ?
                                                3'h1 : st_r.regs[ADDR_WDAY][2:0] + 3'h1;
                  st_nxt.regs[ADDR_DATE][5:0] = dayLast ? 6'h01 :
                                                6'(bcdInc({2'b00, st_r.regs[ADDR_DATE][5:0]}));
                  if (dayLast) begin
                     st_nxt.regs[ADDR_MON][4:0] = (st_r.regs[ADDR_MON][4:0] == MON_LAST) ?
                        5'h01 : 5'(bcdInc({3'b000, st_r.regs[ADDR_MON][4:0]}));
                     if (st_r.regs[ADDR_MON][4:0] == MON_LAST) begin
                        st_nxt.regs[ADDR_YEAR] = (st_r.regs[ADDR_YEAR] == YEAR_LAST) ?
                                                 8'h00 : bcdInc(st_r.regs[ADDR_YEAR]);
                        if (st_r.regs[ADDR_YEAR] == YEAR_LAST &&
                            st_r.regs[ADDR_HOUR][BIT_CENT_EN]) begin
                           st_nxt.regs[ADDR_HOUR][BIT_CENT] =
                              !st_r.regs[ADDR_HOUR][BIT_CENT];
                        end
                     end
                  end
               end
            end
         end
      end
      // Missing oscillation sets the fail flag; set wins over a clearing write
      if (!oscRun) begin
         st_nxt.regs[ADDR_MIN][BIT_OSC_FAIL] = 1'b1;
      end
      // Pin mux: 512 Hz square wave or static level, low only by pulling
      st_nxt.dualOe = st_r.regs[ADDR_CTRL][BIT_FREQ_EN] ? !st_r.div[DIV_TAP_512]
                      : !st_r.regs[ADDR_CTRL][BIT_OUT_LVL];
      st_nxt.odLevel = 1'b0;
      // Synchronous reset; watchdog starts expired so counting waits for the crystal
      if (!rst_b) begin
         st_nxt        = '0;
         st_nxt.regs   = RST_REGS;
         st_nxt.oscCnt = 16'(OSC_TIMEOUT);
         // Bus pins idle high; starting the chain there avoids a false clock edge
         st_nxt.s1     = PINS_IDLE;
         st_nxt.s2     = PINS_IDLE;
         st_nxt.d      = PINS_IDLE;
      end
   end

   // State register
   always_ff @(posedge clk) begin
      st_r <= st_nxt;
   end

   // Pins come straight from state flops
   assign sdaOut  = st_r.odLevel;
   assign sdaOe   = st_r.sdaOe;
   assign dualOut = st_r.odLevel;
   assign dualOe  = st_r.dualOe;

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence dayEnd_s;
      tick && !wrEn && sec59 && min59 && hr23;
   endsequence
   sequence byteDone_s;
      sclFall && !startC && !stopC && st_r.bitCnt == BIT_ACK;
   endsequence

   secWrap_a: assert property (tick && !wrEn && sec59 |=>
      st_r.regs[ADDR_SEC][6:0] == 7'h00 &&
      st_r.regs[ADDR_MIN][6:0] != $past(st_r.regs[ADDR_MIN][6:0])) else $error("seconds wrap");
   hourWrap_a: assert property (dayEnd_s |=> st_r.regs[ADDR_HOUR][5:0] == 6'h00 &&
      st_r.regs[ADDR_WDAY] != $past(st_r.regs[ADDR_WDAY])) else $error("hour wrap");
   wdayWrap_a: assert property (dayEnd_s ##0 st_r.regs[ADDR_WDAY][2:0] == 3'h7
      |=> st_r.regs[ADDR_WDAY][2:0] == 3'h1) else $error("weekday wrap");
   leapFeb_a: assert property (dayEnd_s ##0 (st_r.regs[ADDR_MON] == 8'h02 &&
      st_r.regs[ADDR_DATE] == 8'h28 && st_r.regs[ADDR_YEAR] == 8'h00)
      |=> st_r.regs[ADDR_DATE] == 8'h29) else $error("leap february");
   stopFreeze_a: assert property (st_r.regs[ADDR_SEC][BIT_OSC_STOP] && !wrEn
      |=> $stable(st_r.regs[ADDR_SEC])) else $error("stop bit not freezing");
   failSet_a: assert property (!oscRun |=> st_r.regs[ADDR_MIN][BIT_OSC_FAIL])
      else $error("fail flag not set");
   century_a: assert property (dayEnd_s ##0 (dayLast &&
      st_r.regs[ADDR_MON][4:0] == 5'h12 &&
      st_r.regs[ADDR_YEAR] == 8'h99 && st_r.regs[ADDR_HOUR][BIT_CENT_EN])
      |=> st_r.regs[ADDR_HOUR][BIT_CENT] != $past(st_r.regs[ADDR_HOUR][BIT_CENT]))
      else $error("century toggle");
   ptrWrap_a: assert property (byteDone_s ##0 (st_r.bus == sWrite && st_r.ptr == 3'h7)
      |=> st_r.ptr == 3'h0) else $error("pointer wrap");
   snapshot_a: assert property (byteDone_s ##0
      (st_r.bus == sAddr && wData == {DEV_ID, 1'b1})
      |=> st_r.shadow == $past(st_r.regs) && st_r.sdaOe) else $error("read snapshot");
   pfClear_a: assert property (wrEn && st_r.ptr != ADDR_CTRL
      |=> !st_r.regs[ADDR_CTRL][BIT_PWR_FAIL]) else $error("power fail clear");
   rsvdZero_a: assert property (st_r.regs[ADDR_WDAY][7:3] == 5'h00 &&
      st_r.regs[ADDR_CTRL][5:1] == 5'h00 && st_r.regs[ADDR_MON][7:5] == 3'h0)
      else $error("reserved bit set");
   pinFreq_a: assert property (st_r.regs[ADDR_CTRL][BIT_FREQ_EN] ##1 1'b1
      |-> dualOe == !$past(st_r.div[DIV_TAP_512])) else $error("512 Hz output");
   pinLevel_a: assert property (!st_r.regs[ADDR_CTRL][BIT_FREQ_EN] ##1 1'b1
      |-> dualOe == !$past(st_r.regs[ADDR_CTRL][BIT_OUT_LVL])) else $error("static level");
endmodule : brc_rtc
`default_nettype wire

// file: brc_i2c_master.sv
// Serial bus master model that owns the clock and shares the open-drain data wire
`timescale 1ns/1ps
`default_nettype none
module brc_i2c_master (
   // Clock
   input  wire logic clk,
   // Bus wires
   input  wire logic sdaLine,
   output logic      scl,
   output logic      sdaPull
);
   localparam int Q = 33;  // Quarter bit in clk, about 379 kHz
   // Bus idles released: clock high, data let go to the pull-up
   initial begin
      scl     = 1'b1;
      sdaPull = 1'b0;
   end
   // Pins change only just after a clk edge
   task automatic hold(input int n);
      repeat (n) @(posedge clk);
   endtask : hold
   // Start or repeated start: data falls while clock is high
   task automatic start();
      hold(Q);
      sdaPull <= 1'b0;
      hold(Q);
      scl <= 1'b1;
      hold(Q);
      sdaPull <= 1'b1;
      hold(Q);
      scl <= 1'b0;
   endtask : start
   // Stop: data rises while clock is high, then bus is free
   task automatic stop();
      hold(Q);
      sdaPull <= 1'b1;
      hold(Q);
      scl <= 1'b1;
      hold(Q);
      sdaPull <= 1'b0;
      hold(Q);
   endtask : stop
   // One clock pulse; data set in the low phase, wire sampled mid-high
   task automatic bitx(input logic b, output logic r);
      hold(Q);
      sdaPull <= !b;
      hold(Q);
      scl <= 1'b1;
      hold(Q);
      r = sdaLine;
      hold(Q);
      scl <= 1'b0;
   endtask : bitx
   // Byte out MSB first, then the slave's acknowledge slot
   task automatic wrByte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(b[i], r);
      bitx(1'b1, r);
      ack = !r;
   endtask : wrByte
   // Byte in; acknowledge to go on, no acknowledge on the last one
   task automatic rdByte(input logic more, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
      bitx(!more, r);
   endtask : rdByte
endmodule : brc_i2c_master
`default_nettype wire

// file: testbench.sv
// Self-checking bench of the BCD calendar clock through its serial register port
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import brc_pkg::*;
   logic      clk, rst_b, crystalIn, xtalOn, sclIn, sdaPull, sdaOe, dualOe, sdaOut, dualOut;
   wire logic sdaLine;
   int        failures, samples_checked, cycles, xtalPh;
   // Open-drain wire with pull-up: low when either party pulls
   assign sdaLine = !(sdaOe | sdaPull);
   // Short watchdog so a 160 ns timebase counts as running
   brc_rtc #(.OSC_TIMEOUT(20)) i_brc_rtc (.clk(clk), .rst_b(rst_b), .crystalIn(crystalIn),
      .sclIn(sclIn), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .dualOut(dualOut),
      .dualOe(dualOe));
   brc_i2c_master master (.clk(clk), .sdaLine(sdaLine), .scl(sclIn), .sdaPull(sdaPull));
   initial clk = 1'b0;
   always #10 clk = ~clk;
   // Timebase of 160 ns period, driven on clk edges; stands low until enabled
   always @(posedge clk) begin
      xtalPh <= (xtalPh + 1) % 4;
      if (xtalPh == 3) begin
         crystalIn <= xtalOn & !crystalIn;
      end
   end
   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 90000) begin
         failures++;
         $display("BAD %0t run did not finish", $time);
         conclude();
      end
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   // Start, slave id for write, register address
   task automatic addrWr(input logic [2:0] a);
      logic ack;
      master.start();
      master.wrByte({DEV_ID, 1'b0}, ack);
      check({7'h0, ack}, 8'h01);
      master.wrByte({5'h0, a}, ack);
      check({7'h0, ack}, 8'h01);
   endtask : addrWr
   task automatic wrRegs(input logic [2:0] a, input logic [7:0] d[$]);
      logic ack;
      addrWr(a);
      foreach (d[i]) begin
         master.wrByte(d[i], ack);
         check({7'h0, ack}, 8'h01);
      end
      master.stop();
   endtask : wrRegs
   // Read from the current pointer and compare each byte
   task automatic curRd(input logic [7:0] e[$]);
      logic       ack;
      logic [7:0] d;
      master.start();
      master.wrByte({DEV_ID, 1'b1}, ack);
      check({7'h0, ack}, 8'h01);
      foreach (e[i]) begin
         master.rdByte(i < e.size() - 1, d);
         check(d, e[i]);
      end
      master.stop();
   endtask : curRd
   task automatic rdRegs(input logic [2:0] a, input logic [7:0] e[$]);
      addrWr(a);
      curRd(e);
   endtask : rdRegs
   // Defaults, read wrap past the control register, pointer left after it
   task automatic resetScan();
      check({7'h0, dualOe}, 8'h00);
      check({6'h0, sdaOut, dualOut}, 8'h00);
      rdRegs(3'h7, '{8'h81, 8'h00, 8'h80, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h81});
      curRd('{8'h00});
   endtask : resetScan
   // Foreign id must get no acknowledge
   task automatic wrongId();
      logic ack;
      master.start();
      master.wrByte({DEV_ID ^ 7'h01, 1'b0}, ack);
      check({7'h0, ack}, 8'h00);
      master.stop();
   endtask : wrongId
   // Burst across the wrap, fixed zeros, read-only flag, static low pin
   task automatic writeBurst();
      wrRegs(3'h6, '{8'h23, 8'h3F, 8'h45, 8'h59, 8'h00, 8'hFF});
      rdRegs(3'h6, '{8'h23, 8'h00, 8'h45, 8'hD9, 8'h00, 8'h07});
      check({7'h0, dualOe}, 8'h01);
      check({6'h0, sdaOut, dualOut}, 8'h00);
   endtask : writeBurst
   // With the timebase running the fail flag clears by write
   task automatic oscRun();
      xtalOn <= 1'b1;
      repeat (100) @(posedge clk);
      wrRegs(3'h1, '{8'h12});
      rdRegs(3'h1, '{8'h12});
   endtask : oscRun
   // Pin toggles every 256 clk: 32 timebase edges at 160 ns
   task automatic freqOut();
      int   n;
      logic lvl;
      wrRegs(3'h7, '{8'h40});
      for (int k = 0; k < 2; k++) begin
         lvl = dualOe;
         n = 0;
         while (dualOe === lvl && n < 600) begin
            @(negedge clk);
            n++;
         end
      end
      check({7'h0, (n > 253 && n < 259)}, 8'h01);
   endtask : freqOut
   // Stop bit reads back and raises the fail flag
   task automatic oscStop();
      wrRegs(3'h0, '{8'h80});
      repeat (100) @(posedge clk);
      rdRegs(3'h0, '{8'h80, 8'h92});
   endtask : oscStop
   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : conclude
   initial begin
      rst_b = 1'b0;
      xtalOn = 1'b0;
      crystalIn = 1'b0;
      xtalPh = 0;
      failures = 0;
      samples_checked = 0;
      cycles = 0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      resetScan();
      wrongId();
      writeBurst();
      oscRun();
      freqOut();
      oscStop();
      conclude();
   end
endmodule : testbench
`default_nettype wire
